// ==== mie_pkg.sv ====
package mie_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam logic [7:0] BCD_LIMIT = 8'h09;
    localparam logic [7:0] ADJ_LO = 8'h06;
    localparam logic [7:0] ADJ_HI = 8'h60;
    localparam logic [7:0] ONE = 8'h01;
    // Operation codes presented on the decoded-operation port.
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_DECIMAL_ADJUST = 5'h01;
    localparam logic [4:0] OP_DEC = 5'h02;
    localparam logic [4:0] OP_DECA = 5'h03;
    localparam logic [4:0] OP_INC = 5'h04;
    localparam logic [4:0] OP_INCA = 5'h05;
    localparam logic [4:0] OP_HALT = 5'h06;
    localparam logic [4:0] OP_JMP = 5'h07;
    localparam logic [4:0] OP_MOV_A_M = 5'h08;
    localparam logic [4:0] OP_MOV_A_X = 5'h09;
    localparam logic [4:0] OP_MOV_M_A = 5'h0a;
    localparam logic [4:0] OP_OR_A_M = 5'h0b;
    localparam logic [4:0] OP_OR_A_X = 5'h0c;
    localparam logic [4:0] OP_ORM = 5'h0d;
    localparam logic [4:0] OP_RET = 5'h0e;
    localparam logic [4:0] OP_RET_A_X = 5'h0f;
    localparam logic [4:0] OP_RETURN_FROM_INTERRUPT = 5'h10;
    localparam logic [4:0] OP_RL = 5'h11;
    localparam logic [4:0] OP_RLA = 5'h12;
    localparam logic [4:0] OP_ROTATE_LEFT_THROUGH_CARRY = 5'h13;
    localparam logic [4:0] OP_ROTATE_LEFT_THROUGH_CARRY_A = 5'h14;
    localparam logic [4:0] OP_RR = 5'h15;
    localparam logic [4:0] OP_RRA = 5'h16;
    localparam logic [4:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h17;
    localparam logic [4:0] OP_ROTATE_RIGHT_THROUGH_CARRY_A = 5'h18;
    localparam logic [4:0] OP_SUBTRACT_WITH_BORROW = 5'h19;
    localparam logic [4:0] OP_SUBTRACT_WITH_BORROW_M = 5'h1a;
    typedef enum logic [1:0] {
        MIE_RUN = 2'b00,
        MIE_DUMMY = 2'b01,
        MIE_DOWN = 2'b10
    } mie_state_t;
endpackage

// ==== mie_exec.sv ====
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module mie_exec #(
    parameter int PC_W = mie_pkg::PC_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Decoded instruction
    input wire logic i_valid,
    input wire logic [4:0] i_op,
    input wire logic [7:0] i_imm,
    input wire logic [PC_W-1:0] i_addr,
    // Data memory byte read at the operand address
    input wire logic [7:0] i_mem_rdata,
    // Return stack top
    input wire logic [PC_W-1:0] i_stack_top,
    // Wake-up and watchdog time-out events
    input wire logic i_wake,
    input wire logic i_watchdog_expired,
    // Instruction handshake
    output logic o_ready,
    output logic o_done,
    // Data memory write
    output logic o_mem_we,
    output logic [7:0] o_mem_wdata,
    // Program counter load and stack pop
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_stack_pop,
    // Architectural state
    output logic [7:0] o_working_register,
    output logic o_carry,
    output logic o_half_carry_flag,
    output logic o_zero,
    output logic o_signed_range_exceeded,
    output logic o_global_irq_enable,
    output logic o_powerdown_flag,
    output logic o_watchdog_timeout_flag,
    output logic o_watchdog_clear,
    output logic o_clock_off
);
    mie_pkg::mie_state_t state;
    mie_pkg::mie_state_t next_state;
    logic [7:0] next_wreg;
    logic [7:0] next_wdata;
    logic next_we;
    logic next_c;
    logic next_half;
    logic next_z;
    logic next_range;
    logic next_pc_load;
    logic [PC_W-1:0] next_pc;
    logic next_pop;
    logic [7:0] adj;
    logic [7:0] res;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic go;

    assign o_ready = (state == mie_pkg::MIE_RUN);
    assign go = i_valid && o_ready;

    always_comb begin
        adj = 8'h00;
        res = 8'h00;
        diff = 9'h000;
        diff_lo = 5'h00;
        next_wreg = o_working_register;
        next_wdata = 8'h00;
        next_we = 1'b0;
        next_c = o_carry;
        next_half = o_half_carry_flag;
        next_z = o_zero;
        next_range = o_signed_range_exceeded;
        next_pc_load = 1'b0;
        next_pc = '0;
        next_pop = 1'b0;
        next_state = state;
        case (i_op)
            mie_pkg::OP_DECIMAL_ADJUST: begin
                if (o_working_register[3:0] > mie_pkg::BCD_LIMIT[3:0] || o_half_carry_flag) begin
                    adj = adj | mie_pkg::ADJ_LO;
                end
                if (o_working_register[7:4] > mie_pkg::BCD_LIMIT[3:0] || o_carry) begin
                    adj = adj | mie_pkg::ADJ_HI;
                end
                {next_c, next_wdata} = {1'b0, o_working_register} + {1'b0, adj};
                next_c = next_c | o_carry;
                next_we = 1'b1;
            end
            mie_pkg::OP_DEC, mie_pkg::OP_DECA: begin
                res = i_mem_rdata - mie_pkg::ONE;
                next_z = (res == 8'h00);
                if (i_op == mie_pkg::OP_DEC) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_INC, mie_pkg::OP_INCA: begin
                res = i_mem_rdata + mie_pkg::ONE;
                next_z = (res == 8'h00);
                if (i_op == mie_pkg::OP_INC) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_HALT: begin
                next_state = mie_pkg::MIE_DOWN;
            end
            mie_pkg::OP_JMP: begin
                next_pc_load = 1'b1;
                next_pc = i_addr;
                next_state = mie_pkg::MIE_DUMMY;
            end
            mie_pkg::OP_MOV_A_M: next_wreg = i_mem_rdata;
            mie_pkg::OP_MOV_A_X: next_wreg = i_imm;
            mie_pkg::OP_MOV_M_A: begin
                next_we = 1'b1;
                next_wdata = o_working_register;
            end
            mie_pkg::OP_OR_A_M, mie_pkg::OP_OR_A_X, mie_pkg::OP_ORM: begin
                res = o_working_register | ((i_op == mie_pkg::OP_OR_A_X) ? i_imm : i_mem_rdata);
                next_z = (res == 8'h00);
                if (i_op == mie_pkg::OP_ORM) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_RET, mie_pkg::OP_RET_A_X, mie_pkg::OP_RETURN_FROM_INTERRUPT: begin
                next_pc_load = 1'b1;
                next_pc = i_stack_top;
                next_pop = 1'b1;
                next_state = mie_pkg::MIE_DUMMY;
                if (i_op == mie_pkg::OP_RET_A_X) begin
                    next_wreg = i_imm;
                end
            end
            mie_pkg::OP_RL, mie_pkg::OP_RLA: begin
                res = {i_mem_rdata[6:0], i_mem_rdata[7]};
                if (i_op == mie_pkg::OP_RL) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_A: begin
                res = {i_mem_rdata[6:0], o_carry};
                next_c = i_mem_rdata[7];
                if (i_op == mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_RR, mie_pkg::OP_RRA: begin
                res = {i_mem_rdata[0], i_mem_rdata[7:1]};
                if (i_op == mie_pkg::OP_RR) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY, mie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_A: begin
                res = {o_carry, i_mem_rdata[7:1]};
                next_c = i_mem_rdata[0];
                if (i_op == mie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            mie_pkg::OP_SUBTRACT_WITH_BORROW, mie_pkg::OP_SUBTRACT_WITH_BORROW_M: begin
                // Borrow is the inverted carry, so a set carry means nothing is owed.
                diff = {1'b0, o_working_register} - {1'b0, i_mem_rdata}
                    - {8'h00, ~o_carry};
                diff_lo = {1'b0, o_working_register[3:0]} - {1'b0, i_mem_rdata[3:0]}
                    - {4'h0, ~o_carry};
                res = diff[7:0];
                next_c = ~diff[8];
                next_half = ~diff_lo[4];
                next_z = (res == 8'h00);
                next_range = (o_working_register[7] ^ i_mem_rdata[7])
                    & (o_working_register[7] ^ res[7]);
                if (i_op == mie_pkg::OP_SUBTRACT_WITH_BORROW_M) begin
                    next_we = 1'b1;
                    next_wdata = res;
                end else begin
                    next_wreg = res;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= mie_pkg::MIE_RUN;
        end else begin
            case (state)
                mie_pkg::MIE_RUN: begin
                    if (go) begin
                        state <= next_state;
                    end
                end
                mie_pkg::MIE_DUMMY: state <= mie_pkg::MIE_RUN;
                mie_pkg::MIE_DOWN: begin
                    if (i_wake) begin
                        state <= mie_pkg::MIE_RUN;
                    end
                end
                default: state <= mie_pkg::MIE_RUN;
            endcase
        end
    end

    // Flags and the working register only move on an accepted instruction.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_working_register <= 8'h00;
            o_carry <= 1'b0;
            o_half_carry_flag <= 1'b0;
            o_zero <= 1'b0;
            o_signed_range_exceeded <= 1'b0;
        end else if (go) begin
            o_working_register <= next_wreg;
            o_carry <= next_c;
            o_half_carry_flag <= next_half;
            o_zero <= next_z;
            o_signed_range_exceeded <= next_range;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mem_we <= 1'b0;
            o_mem_wdata <= 8'h00;
            o_pc_load <= 1'b0;
            o_pc_value <= '0;
            o_stack_pop <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_mem_we <= go && next_we;
            o_mem_wdata <= go ? next_wdata : o_mem_wdata;
            o_pc_load <= go && next_pc_load;
            o_pc_value <= go ? next_pc : o_pc_value;
            o_stack_pop <= go && next_pop;
            o_done <= go;
        end
    end

    // Interrupt enable is owned elsewhere too; this copy only records the return's effect.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_global_irq_enable <= 1'b0;
        end else if (go && i_op == mie_pkg::OP_RETURN_FROM_INTERRUPT) begin
            o_global_irq_enable <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_powerdown_flag <= 1'b0;
            o_watchdog_timeout_flag <= 1'b0;
            o_watchdog_clear <= 1'b0;
        end else begin
            o_watchdog_clear <= go && i_op == mie_pkg::OP_HALT;
            // A time-out in the cycle of power-down entry is kept, so that it is never lost.
            if (i_watchdog_expired) begin
                o_watchdog_timeout_flag <= 1'b1;
            end else if (go && i_op == mie_pkg::OP_HALT) begin
                o_watchdog_timeout_flag <= 1'b0;
            end
            if (go && i_op == mie_pkg::OP_HALT) begin
                o_powerdown_flag <= 1'b1;
            end
        end
    end

    assign o_clock_off = (state == mie_pkg::MIE_DOWN);

    chk_jump_two_cycles: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_JMP |=> o_pc_load && !o_ready ##1 o_ready)
        else $error("jump did not take two cycles");
    chk_ret_pops_stack: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_RET |=> o_stack_pop && o_pc_value == $past(i_stack_top))
        else $error("return did not reload counter");
    chk_return_from_interrupt_sets_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_RETURN_FROM_INTERRUPT |=> o_global_irq_enable)
        else $error("interrupt return left enable clear");
    chk_halt_flags_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_HALT |=> o_powerdown_flag
        && o_watchdog_timeout_flag == $past(i_watchdog_expired)
        && o_watchdog_clear && o_clock_off)
        else $error("power-down entry flags wrong");
    chk_inca_no_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_INCA |=> !o_mem_we
        && o_working_register == $past(i_mem_rdata) + 8'h01)
        else $error("register form touched memory");
    chk_sub_carry_sign: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_SUBTRACT_WITH_BORROW && o_carry
        |=> o_carry == ($past(o_working_register) >= $past(i_mem_rdata)))
        else $error("subtract carry wrong");
    chk_rl_rotates: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_RL |=> o_mem_we
        && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])}
        && $stable(o_carry))
        else $error("rotate left wrong");
    chk_mov_no_flags: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        go && i_op == mie_pkg::OP_MOV_A_X |=> o_working_register == $past(i_imm)
        && $stable(o_zero) && $stable(o_carry))
        else $error("move changed flags");
    cov_jump: cover property (@(posedge i_clk) go && i_op == mie_pkg::OP_JMP);
    cov_halt_wake: cover property (@(posedge i_clk) o_clock_off ##1 !o_clock_off);
    cov_adjust: cover property (@(posedge i_clk) go && i_op == mie_pkg::OP_DECIMAL_ADJUST);
endmodule

// ==== mie_far.sv ====
`timescale 1ns/1ps
module mie_far #(
    parameter int PC_W = 15
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Operand address chosen by the bench
    input wire logic [3:0] i_maddr,
    // Requests from the execute block
    input wire logic i_mem_we,
    input wire logic [7:0] i_mem_wdata,
    input wire logic i_pc_load,
    input wire logic [PC_W-1:0] i_pc_value,
    input wire logic i_stack_pop,
    // Answers to the execute block
    output logic [7:0] o_mem_rdata,
    output logic [PC_W-1:0] o_stack_top
);
    logic [7:0] mem [16];
    logic [PC_W-1:0] stack [4];
    logic [1:0] sp;
    logic [3:0] waddr;
    logic [PC_W-1:0] pc;
    assign o_mem_rdata = mem[i_maddr];
    assign o_stack_top = stack[sp - 2'h1];
    // The write lands a cycle after acceptance, so the address of the taking edge is kept.
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            waddr <= 4'h0;
            sp <= 2'h0;
            pc <= {PC_W{1'b0}};
        end else begin
            waddr <= i_maddr;
            if (i_mem_we) begin
                mem[waddr] <= i_mem_wdata;
            end
            if (i_pc_load) begin
                pc <= i_pc_value;
            end
            if (i_stack_pop) begin
                sp <= sp - 2'h1;
            end
        end
    end
    // Only four levels are modelled, so deeper nesting wraps without warning.
    task automatic push(input logic [PC_W-1:0] v);
        stack[sp] = v;
        sp = sp + 2'h1;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic i_clk, i_rst_b, i_valid, i_wake, i_watchdog_expired;
    logic [4:0] i_op;
    logic [7:0] i_imm, i_mem_rdata;
    logic [14:0] i_addr, i_stack_top;
    logic [3:0] maddr;
    logic o_ready, o_done, o_mem_we, o_pc_load, o_stack_pop;
    logic [7:0] o_mem_wdata, o_working_register;
    logic [14:0] o_pc_value;
    logic o_carry, o_half_carry_flag, o_zero, o_signed_range_exceeded, o_global_irq_enable;
    logic o_powerdown_flag, o_watchdog_timeout_flag, o_watchdog_clear, o_clock_off;
    int mismatches = 0;
    int checked = 0;
    mie_exec #(.PC_W(15)) DUT (.i_clk, .i_rst_b, .i_valid, .i_op, .i_imm, .i_addr,
        .i_mem_rdata, .i_stack_top, .i_wake, .i_watchdog_expired, .o_ready, .o_done,
        .o_mem_we, .o_mem_wdata,
        .o_pc_load, .o_pc_value, .o_stack_pop, .o_working_register, .o_carry,
        .o_half_carry_flag, .o_zero, .o_signed_range_exceeded, .o_global_irq_enable,
        .o_powerdown_flag, .o_watchdog_timeout_flag, .o_watchdog_clear, .o_clock_off);
    mie_far #(.PC_W(15)) far (.i_clk, .i_rst_b, .i_maddr(maddr), .i_mem_we(o_mem_we),
        .i_mem_wdata(o_mem_wdata), .i_pc_load(o_pc_load), .i_pc_value(o_pc_value),
        .i_stack_pop(o_stack_pop), .o_mem_rdata(i_mem_rdata), .o_stack_top(i_stack_top));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    function automatic logic [19:0] st();
        return {3'h0, o_mem_we, o_working_register, 3'h0, o_zero, o_carry,
            o_half_carry_flag, o_signed_range_exceeded, o_global_irq_enable};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Valid is left high so that a following offer lands back to back.
    task automatic issue(input logic [4:0] op, input logic [7:0] imm, input logic [3:0] m);
        i_valid <= 1'b1;
        i_op <= op;
        i_imm <= imm;
        maddr <= m;
        @(posedge i_clk);
        #1;
    endtask
    task automatic idle();
        i_valid <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    task automatic t_sub();
        issue(mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_A, 8'h00, 4'h3);
        chk(st(), 20'h00008);
        issue(mie_pkg::OP_MOV_A_M, 8'h00, 4'h1);
        chk(st(), 20'h01308);
        issue(mie_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 4'h2);
        chk(st(), 20'h0120c);
        issue(mie_pkg::OP_DECIMAL_ADJUST, 8'h00, 4'h4);
        chk({st(), o_mem_wdata}, {20'h1120c, 8'h78});
        issue(mie_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 4'h5);
        chk(st(), 20'h0f204);
        issue(mie_pkg::OP_SUBTRACT_WITH_BORROW_M, 8'h00, 4'h6);
        chk({st(), o_mem_wdata}, {20'h1f21c, 8'h00});
        idle();
        chk(far.mem[6], 20'h0);
    endtask
    task automatic t_daa();
        issue(mie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_A, 8'h00, 4'h7);
        chk(st(), 20'h08a14);
        issue(mie_pkg::OP_DECIMAL_ADJUST, 8'h00, 4'h0);
        chk({st(), o_mem_wdata}, {20'h18a14, 8'h90});
        issue(mie_pkg::OP_MOV_A_X, 8'ha3, 4'h0);
        chk(st(), 20'h0a314);
        issue(mie_pkg::OP_DECIMAL_ADJUST, 8'h00, 4'h0);
        chk({st(), o_mem_wdata}, {20'h1a31c, 8'h09});
    endtask
    task automatic t_incdec();
        issue(mie_pkg::OP_DECA, 8'h00, 4'h9);
        chk(st(), 20'h0ff0c);
        issue(mie_pkg::OP_INC, 8'h00, 4'h8);
        chk({st(), o_mem_wdata}, {20'h1ff1c, 8'h00});
        issue(mie_pkg::OP_INCA, 8'h00, 4'ha);
        chk(st(), 20'h0010c);
        issue(mie_pkg::OP_DEC, 8'h00, 4'h2);
        chk({st(), o_mem_wdata}, {20'h1011c, 8'h00});
        idle();
        chk({far.mem[9], far.mem[10]}, 20'h0);
    endtask
    task automatic t_or();
        issue(mie_pkg::OP_OR_A_X, 8'h00, 4'h0);
        chk(st(), 20'h0010c);
        issue(mie_pkg::OP_MOV_A_X, 8'h00, 4'h0);
        chk(st(), 20'h0000c);
        issue(mie_pkg::OP_OR_A_M, 8'h00, 4'ha);
        chk(st(), 20'h0001c);
        issue(mie_pkg::OP_ORM, 8'h00, 4'hc);
        chk({st(), o_mem_wdata}, {20'h1000c, 8'h5a});
        idle();
    endtask
    task automatic t_rot();
        logic [4:0] rop [8] = '{5'h11, 5'h12, 5'h15, 5'h16, 5'h13, 5'h17, 5'h14, 5'h18};
        logic [7:0] rexp [8] = '{8'h82, 8'h82, 8'ha0, 8'ha0, 8'h83, 8'h20, 8'h83, 8'h20};
        logic rc [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 8; k++) begin
            far.mem[11] = 8'h41;
            issue(rop[k], 8'h00, 4'hb);
            chk({o_mem_we, rop[k][0] ? o_mem_wdata : o_working_register, o_zero, o_carry,
                o_half_carry_flag}, {rop[k][0], rexp[k], 1'b0, rc[k], 1'b1});
            idle();
        end
    endtask
    task automatic t_jump();
        i_addr <= 15'h1234;
        issue(mie_pkg::OP_JMP, 8'h00, 4'h0);
        chk({o_ready, o_done, o_pc_load, o_pc_value}, {3'b011, 15'h1234});
        issue(mie_pkg::OP_MOV_A_X, 8'h77, 4'h0);
        chk({o_ready, o_done}, 20'h2);
        issue(mie_pkg::OP_MOV_A_X, 8'h77, 4'h0);
        chk({o_done, st()}, {1'b1, 20'h0770c});
        idle();
        chk(far.pc, 20'h01234);
    endtask
    task automatic t_ret();
        far.push(15'h0abc);
        far.push(15'h0def);
        issue(mie_pkg::OP_RET_A_X, 8'h3c, 4'h0);
        chk({st(), o_stack_pop, o_pc_value}, {20'h03c0c, 1'b1, 15'h0def});
        idle();
        issue(mie_pkg::OP_RET, 8'h00, 4'h0);
        chk({st(), o_pc_load, o_pc_value}, {20'h03c0c, 1'b1, 15'h0abc});
        idle();
        far.push(15'h0123);
        issue(mie_pkg::OP_RETURN_FROM_INTERRUPT, 8'h00, 4'h0);
        chk({st(), o_pc_load, o_pc_value}, {20'h03c0d, 1'b1, 15'h0123});
        idle();
    endtask
    task automatic t_halt();
        i_watchdog_expired <= 1'b1;
        issue(mie_pkg::OP_NOP, 8'h00, 4'h0);
        i_watchdog_expired <= 1'b0;
        chk({st(), o_pc_load, o_stack_pop, o_done, o_watchdog_timeout_flag},
            {20'h03c0d, 4'b0011});
        issue(mie_pkg::OP_HALT, 8'h00, 4'h0);
        chk({o_clock_off, o_powerdown_flag, o_watchdog_timeout_flag, o_watchdog_clear,
            o_ready}, 20'h1a);
        issue(mie_pkg::OP_MOV_A_X, 8'h55, 4'h0);
        chk({o_clock_off, o_watchdog_clear, o_done, st()}, {3'b100, 20'h03c0d});
        i_wake <= 1'b1;
        @(posedge i_clk);
        #1;
        chk(o_ready, 20'h1);
        i_wake <= 1'b0;
        @(posedge i_clk);
        #1;
        chk({o_done, o_working_register}, 20'h155);
        idle();
    endtask
    task automatic t_ovf();
        issue(mie_pkg::OP_MOV_A_X, 8'h80, 4'h1);
        chk(st(), 20'h0800d);
        issue(mie_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 4'h1);
        chk(st(), 20'h06d0b);
        issue(mie_pkg::OP_MOV_M_A, 8'h00, 4'hd);
        chk({st(), o_mem_wdata}, {20'h16d0b, 8'h6d});
        idle();
        chk(far.mem[13], 8'h6d);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
    initial begin
        i_rst_b = 1'b0;
        i_valid = 1'b0;
        i_wake = 1'b0;
        i_watchdog_expired = 1'b0;
        i_op = 5'h00;
        i_imm = 8'h00;
        i_addr = 15'h0000;
        maddr = 4'h0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1;
        far.mem[1] = 8'h13;
        far.mem[2] = 8'h01;
        far.mem[3] = 8'h80;
        far.mem[5] = 8'h20;
        far.mem[6] = 8'hf1;
        far.mem[7] = 8'h14;
        far.mem[8] = 8'hff;
        far.mem[9] = 8'h00;
        far.mem[10] = 8'h00;
        far.mem[12] = 8'h5a;
        chk({o_ready, st()}, {1'b1, 20'h0});
        t_sub();
        t_daa();
        t_incdec();
        t_or();
        t_rot();
        t_jump();
        t_ret();
        t_halt();
        t_ovf();
        print_verdict();
    end
endmodule
